// >>> rtl/acd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - M divider code 1..63 divides by code, zero divides by 64
// - Modulator divider codes 0,1,2 divide by 1,2,4; code 3 reserved
// - Auto clock detection overrides every divider value field
// - Extension bit 2 is primary bit-clock divider MSB above its low byte
// - Extension bit 1 is secondary bit-clock divider MSB above its low byte
// - Nine-bit bit-clock dividers divide by code, zero divides by 512
// - Analog N-M divider code 1..63 divides by code, zero by 64
// - Enable register: bit 2 N, bit 1 M, bit 0 PDM divider
// - Reserved bits read zero; software writes only zero into them
module acd_top
  import acd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Internally derived codes used under auto detection
  input wire logic [M_W-1:0] auto_m_code,
  input wire logic [MOD_W-1:0] auto_mod_code,
  input wire logic [BIT_W-1:0] auto_pbit_code,
  input wire logic [BIT_W-1:0] auto_sbit_code,
  input wire logic [NM_W-1:0] auto_nm_code,
  // Divided clocks and enables
  output logic m_clk,
  output logic mod_clk,
  output logic pbit_clk,
  output logic sbit_clk,
  output logic nm_clk,
  output logic pdm_divider_enable
);

  // Register storage
  logic [7:0] m_mod_q;
  logic [7:0] ext_q;
  logic [7:0] plow_q;
  logic [7:0] slow_q;
  logic [7:0] nm_q;
  logic [7:0] en_q;
  logic [7:0] ctrl_q;

  // Bus signals
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [7:0] rd_d;
  logic [7:0] stat;

  // Effective codes and ratios
  logic auto_on;
  logic [M_W-1:0] m_code;
  logic [MOD_W-1:0] mod_code;
  logic [BIT_W-1:0] pbit_code;
  logic [BIT_W-1:0] sbit_code;
  logic [NM_W-1:0] nm_code;
  logic [M_W:0] m_ratio;
  logic [MOD_W:0] mod_ratio;
  logic [BIT_W:0] pbit_ratio;
  logic [BIT_W:0] sbit_ratio;
  logic [NM_W:0] nm_ratio;

  // Divider pulses
  logic m_tick;
  logic mod_tick;
  logic nm_tick;

  // Request decode: word index, new request only while no ack pending
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];

  // Single-cycle acknowledge, dropped the cycle after it is given
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // M and modulator divider register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      m_mod_q <= RST_M_MOD;
    end else if (wr && idx == IDX_M_MOD) begin
      m_mod_q <= wb_dat_i[7:0] & MSK_M_MOD;
    end
  end

  // Bit-clock extension register; reserved bits never stored
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_q <= RST_EXT;
    end else if (wr && idx == IDX_EXT) begin
      ext_q <= wb_dat_i[7:0] & MSK_EXT;
    end
  end

  // Primary and secondary bit-clock low bytes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      plow_q <= RST_PLOW;
      slow_q <= RST_SLOW;
    end else if (wr && idx == IDX_PLOW) begin
      plow_q <= wb_dat_i[7:0] & MSK_PLOW;
    end else if (wr && idx == IDX_SLOW) begin
      slow_q <= wb_dat_i[7:0] & MSK_SLOW;
    end
  end

  // Analog N-M divider register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nm_q <= RST_NM;
    end else if (wr && idx == IDX_NM) begin
      nm_q <= wb_dat_i[7:0] & MSK_NM;
    end
  end

  // Divider enable register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_q <= RST_EN;
    end else if (wr && idx == IDX_EN) begin
      en_q <= wb_dat_i[7:0] & MSK_EN;
    end
  end

  // Auto detection control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= RST_CTRL;
    end else if (wr && idx == IDX_CTRL) begin
      ctrl_q <= wb_dat_i[7:0] & MSK_CTRL;
    end
  end

  // Live divider state for software
  assign stat = {3'b000, nm_clk, sbit_clk, pbit_clk, mod_clk, m_clk};

  // Read mux; unmapped indices read zero
  always_comb begin
    case (idx)
      IDX_M_MOD: rd_d = m_mod_q;
      IDX_EXT: rd_d = ext_q;
      IDX_PLOW: rd_d = plow_q;
      IDX_SLOW: rd_d = slow_q;
      IDX_NM: rd_d = nm_q;
      IDX_EN: rd_d = en_q;
      IDX_CTRL: rd_d = ctrl_q;
      IDX_STAT: rd_d = stat;
      default: rd_d = 8'h00;
    endcase
  end

  // Read data captured with the acknowledge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dat_q <= 32'h0000_0000;
    end else if (req) begin
      dat_q <= {24'h00_0000, rd_d};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pdm_divider_enable = en_q[EN_PDM_BIT];

  // Code selection: auto detection replaces all stored divider codes
  assign auto_on = ctrl_q[CTRL_AUTO_BIT];
  assign m_code = auto_on ? auto_m_code : m_mod_q[M_MSB:M_LSB];
  assign mod_code = auto_on ? auto_mod_code : m_mod_q[MOD_MSB:0];
  assign pbit_code = auto_on ? auto_pbit_code : {ext_q[EXT_P_BIT], plow_q};
  assign sbit_code = auto_on ? auto_sbit_code : {ext_q[EXT_S_BIT], slow_q};
  assign nm_code = auto_on ? auto_nm_code : nm_q[NM_MSB:0];

  // Zero codes map to the full power-of-two ratio
  assign m_ratio = (m_code == '0) ? {1'b1, {M_W{1'b0}}} : {1'b0, m_code};
  assign pbit_ratio = (pbit_code == '0) ? {1'b1, {BIT_W{1'b0}}} : {1'b0, pbit_code};
  assign sbit_ratio = (sbit_code == '0) ? {1'b1, {BIT_W{1'b0}}} : {1'b0, sbit_code};
  assign nm_ratio = (nm_code == '0) ? {1'b1, {NM_W{1'b0}}} : {1'b0, nm_code};

  // Modulator ratio 1/2/4; reserved code 3 falls back to 4
  always_comb begin
    case (mod_code)
      2'd0: mod_ratio = 3'd1;
      2'd1: mod_ratio = 3'd2;
      default: mod_ratio = 3'd4;
    endcase
  end

  // M divider on the source clock, gated by its enable
  acd_div #(.W(M_W)) u_m_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .en(en_q[EN_M_BIT]),
    .tick_in(1'b1),
    .ratio(m_ratio),
    .tick_q(m_tick),
    .clk_q(m_clk)
  );

  // Modulator divider follows the M divider output
  acd_div #(.W(MOD_W)) u_mod_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .en(en_q[EN_M_BIT]),
    .tick_in(m_tick),
    .ratio(mod_ratio),
    .tick_q(mod_tick),
    .clk_q(mod_clk)
  );

  // Primary port bit-clock divider
  acd_div #(.W(BIT_W)) u_pbit_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .en(1'b1),
    .tick_in(1'b1),
    .ratio(pbit_ratio),
    .tick_q(),
    .clk_q(pbit_clk)
  );

  // Secondary port bit-clock divider
  acd_div #(.W(BIT_W)) u_sbit_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .en(1'b1),
    .tick_in(1'b1),
    .ratio(sbit_ratio),
    .tick_q(),
    .clk_q(sbit_clk)
  );

  // Analog N-M divider, running behind the N divider enable
  acd_div #(.W(NM_W)) u_nm_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .en(en_q[EN_N_BIT]),
    .tick_in(1'b1),
    .ratio(nm_ratio),
    .tick_q(nm_tick),
    .clk_q(nm_clk)
  );

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_m_off;
    !en_q[EN_M_BIT] ##1 !en_q[EN_M_BIT];
  endsequence

  sequence s_en_wr;
    wr && idx == IDX_EN;
  endsequence

  sequence s_ext_rd;
    req && !wb_we_i && idx == IDX_EXT;
  endsequence

  sequence s_m_run1;
    en_q[EN_M_BIT] && m_ratio == 7'd1 ##1 en_q[EN_M_BIT] && m_ratio == 7'd1;
  endsequence

  chk_m_zero_ratio: assert property (
    (!auto_on && m_mod_q[M_MSB:M_LSB] == 6'd0) |-> m_ratio == 7'd64)
    else $error("M divider zero code not 64");

  chk_m_div_one: assert property (
    s_m_run1 |-> m_tick)
    else $error("M divider by one missed a pulse");

  chk_mod_by_four: assert property (
    (!auto_on && m_mod_q[MOD_MSB:0] == 2'd2) |-> mod_ratio == 3'd4)
    else $error("Modulator code 2 not divide by 4");

  chk_auto_override: assert property (
    auto_on |-> (m_code == auto_m_code && pbit_code == auto_pbit_code
      && nm_code == auto_nm_code))
    else $error("Auto detection did not override codes");

  chk_pbit_msb_join: assert property (
    !auto_on |-> pbit_ratio[8:0] == {ext_q[2], plow_q} || pbit_ratio == 10'd512)
    else $error("Primary bit-clock code mis-joined");

  chk_sbit_msb_join: assert property (
    (!auto_on && {ext_q[1], slow_q} != 9'd0) |-> sbit_ratio == {1'b0, ext_q[1], slow_q})
    else $error("Secondary bit-clock code mis-joined");

  chk_bit_zero_512: assert property (
    (!auto_on && ext_q[2] == 1'b0 && plow_q == 8'h00) |-> pbit_ratio == 10'd512)
    else $error("Bit-clock zero code not 512");

  chk_nm_zero_ratio: assert property (
    (!auto_on && nm_q[5:0] == 6'd0) |-> nm_ratio == 7'd64)
    else $error("N-M divider zero code not 64");

  chk_enable_write: assert property (
    s_en_wr |=> en_q[2:0] == $past(wb_dat_i[2:0]) && pdm_divider_enable == $past(wb_dat_i[0]))
    else $error("Enable bits not taken from write");

  chk_resv_read_zero: assert property (
    s_ext_rd |=> wb_ack_o && wb_dat_o[7:3] == 5'd0 && wb_dat_o[0] == 1'b0)
    else $error("Reserved bits read nonzero");

  chk_m_off_hold: assert property (
    s_m_off |-> !m_clk && !m_tick && !mod_clk && !mod_tick)
    else $error("Disabled M divider still active");

  chk_nm_off_hold: assert property (
    !en_q[EN_N_BIT] |=> !nm_clk && !nm_tick)
    else $error("Disabled N-M divider still active");

  chk_mod_by_two: assert property (
    (!auto_on && m_mod_q[MOD_MSB:0] == 2'd1) |-> mod_ratio == 3'd2)
    else $error("Modulator code 1 not divide by 2");

  chk_sbit_zero_512: assert property (
    (!auto_on && {ext_q[EXT_S_BIT], slow_q} == 9'd0) |-> sbit_ratio == 10'd512)
    else $error("Secondary bit-clock zero code not 512");

  chk_auto_mod_sbit: assert property (
    auto_on |-> (mod_code == auto_mod_code && sbit_code == auto_sbit_code))
    else $error("Auto detection did not override modulator or secondary codes");

endmodule : acd_top
`default_nettype wire

// >>> rtl/acd_pkg.sv
// Shared constants for the audio clock divider configuration block
package acd_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_M_MOD = 8'h3a;
  localparam logic [7:0] IDX_EXT = 8'h3b;
  localparam logic [7:0] IDX_PLOW = 8'h3c;
  localparam logic [7:0] IDX_SLOW = 8'h3d;
  localparam logic [7:0] IDX_NM = 8'h3e;
  localparam logic [7:0] IDX_EN = 8'h44;
  localparam logic [7:0] IDX_CTRL = 8'h50;
  localparam logic [7:0] IDX_STAT = 8'h51;

  // Reset values
  localparam logic [7:0] RST_M_MOD = 8'h04;
  localparam logic [7:0] RST_EXT = 8'h00;
  localparam logic [7:0] RST_PLOW = 8'h01;
  localparam logic [7:0] RST_SLOW = 8'h01;
  localparam logic [7:0] RST_NM = 8'h01;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // Writable bits; all others are reserved and read as zero
  localparam logic [7:0] MSK_M_MOD = 8'hff;
  localparam logic [7:0] MSK_EXT = 8'h06;
  localparam logic [7:0] MSK_PLOW = 8'hff;
  localparam logic [7:0] MSK_SLOW = 8'hff;
  localparam logic [7:0] MSK_NM = 8'h3f;
  localparam logic [7:0] MSK_EN = 8'h07;
  localparam logic [7:0] MSK_CTRL = 8'h01;

  // Field positions
  localparam int M_MSB = 7;
  localparam int M_LSB = 2;
  localparam int MOD_MSB = 1;
  localparam int EXT_P_BIT = 2;
  localparam int EXT_S_BIT = 1;
  localparam int NM_MSB = 5;
  localparam int EN_N_BIT = 2;
  localparam int EN_M_BIT = 1;
  localparam int EN_PDM_BIT = 0;
  localparam int CTRL_AUTO_BIT = 0;

  // Divider code widths
  localparam int M_W = 6;
  localparam int MOD_W = 2;
  localparam int BIT_W = 9;
  localparam int NM_W = 6;

endpackage : acd_pkg

// >>> rtl/acd_div.sv
`timescale 1ns/1ps
`default_nettype none
// Generic clock-enable divider: one output pulse per ratio source ticks
module acd_div #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic en,
  input wire logic tick_in,
  input wire logic [W:0] ratio,
  // Divided outputs
  output logic tick_q,
  output logic clk_q
);

  logic [W-1:0] count_q;
  logic wrap;

  // Last source tick of a period; >= guards a ratio cut mid-count
  assign wrap = ({1'b0, count_q} >= (ratio - {{W{1'b0}}, 1'b1}));

  // Counter, pulse and square output; cleared while disabled
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !en) begin
      count_q <= '0;
      tick_q <= 1'b0;
      clk_q <= 1'b0;
    end else if (tick_in) begin
      if (wrap) begin
        count_q <= '0;
        tick_q <= 1'b1;
        clk_q <= ~clk_q;
      end else begin
        count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        tick_q <= 1'b0;
      end
    end else begin
      tick_q <= 1'b0;
    end
  end

endmodule : acd_div
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import acd_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [M_W-1:0] auto_m_code = '0;
  logic [MOD_W-1:0] auto_mod_code = '0;
  logic [BIT_W-1:0] auto_pbit_code = '0, auto_sbit_code = '0;
  logic [NM_W-1:0] auto_nm_code = '0;
  logic m_clk, mod_clk, pbit_clk, sbit_clk, nm_clk, pdm_divider_enable;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  acd_top acd_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .auto_m_code(auto_m_code), .auto_mod_code(auto_mod_code),
    .auto_pbit_code(auto_pbit_code), .auto_sbit_code(auto_sbit_code),
    .auto_nm_code(auto_nm_code), .m_clk(m_clk), .mod_clk(mod_clk), .pbit_clk(pbit_clk),
    .sbit_clk(sbit_clk), .nm_clk(nm_clk), .pdm_divider_enable(pdm_divider_enable));
  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One classic bus cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, d};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n == 100) check("ack", 32'h0, 32'h1);
  endtask : wb_xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, idx, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, idx, 8'h00, q);
    check("reg", q, {24'h00_0000, exp});
  endtask : rd_chk
  function automatic logic pick(input int i);
    case (i)
      0: return m_clk;
      1: return mod_clk;
      2: return pbit_clk;
      3: return sbit_clk;
      default: return nm_clk;
    endcase
  endfunction : pick
  // Cycles between two toggles of one output, after two settling toggles
  task automatic measure(input int i, input int exp);
    int n;
    logic v;
    n = 0;
    repeat (3) begin
      n = 0;
      v = pick(i);
      while (pick(i) === v && n < 2000) begin
        @(negedge sys_clk);
        n++;
      end
    end
    check("half period", n, exp);
  endtask : measure
  task automatic t_reset_and_reserved();
    logic [7:0] idx[6] = '{IDX_M_MOD, IDX_EXT, IDX_PLOW, IDX_SLOW, IDX_NM, IDX_EN};
    logic [7:0] rst[6] = '{RST_M_MOD, RST_EXT, RST_PLOW, RST_SLOW, RST_NM, RST_EN};
    logic [7:0] msk[6] = '{8'hff, 8'h06, 8'hff, 8'hff, 8'h3f, 8'h07};
    for (int k = 0; k < 6; k++) rd_chk(idx[k], rst[k]);
    for (int k = 0; k < 6; k++) begin
      wr(idx[k], msk[k]);
      rd_chk(idx[k], msk[k]);
    end
    check("pdm enable", pdm_divider_enable, 1'b1);
    wr(8'h40, 8'h5a);
    rd_chk(8'h40, 8'h00);
  endtask : t_reset_and_reserved
  task automatic t_disabled();
    logic [31:0] q;
    wr(IDX_EN, 8'h00);
    repeat (200) @(posedge sys_clk);
    check("pdm enable", pdm_divider_enable, 1'b0);
    check("idle clocks", {m_clk, mod_clk, nm_clk}, 3'b000);
    wb_xfer(1'b0, IDX_STAT, 8'h00, q);
    check("status idle", q & 32'h0000_0013, 32'h0000_0000);
  endtask : t_disabled
  task automatic t_m_and_modulator();
    int half[4] = '{2, 4, 8, 8};
    wr(IDX_EN, 8'h02);
    wr(IDX_M_MOD, 8'h04);
    measure(0, 1);
    wr(IDX_M_MOD, 8'h0c);
    measure(0, 3);
    wr(IDX_M_MOD, 8'h00);
    measure(0, 64);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_M_MOD, 8'h08 | c[7:0]);
      measure(1, half[c]);
    end
  endtask : t_m_and_modulator
  task automatic t_analog_nm();
    wr(IDX_EN, 8'h04);
    wr(IDX_NM, 8'h05);
    measure(4, 5);
    wr(IDX_NM, 8'h00);
    measure(4, 64);
  endtask : t_analog_nm
  task automatic t_bitclocks();
    wr(IDX_EXT, 8'h04);
    wr(IDX_PLOW, 8'h00);
    measure(2, 256);
    wr(IDX_EXT, 8'h02);
    wr(IDX_SLOW, 8'h02);
    measure(3, 258);
    wr(IDX_EXT, 8'h00);
    wr(IDX_SLOW, 8'h00);
    measure(2, 512);
    measure(3, 512);
    wr(IDX_PLOW, 8'h07);
    measure(2, 7);
  endtask : t_bitclocks
  task automatic t_auto();
    wr(IDX_EN, 8'h06);
    wr(IDX_M_MOD, 8'h14);
    @(posedge sys_clk);
    auto_m_code <= 6'h02;
    auto_mod_code <= 2'h1;
    auto_nm_code <= 6'h03;
    auto_pbit_code <= 9'h009;
    auto_sbit_code <= 9'h00b;
    wr(IDX_CTRL, 8'h01);
    measure(0, 2);
    measure(1, 4);
    measure(4, 3);
    measure(2, 9);
    measure(3, 11);
    wr(IDX_CTRL, 8'h00);
    measure(0, 5);
  endtask : t_auto
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset_and_reserved();
    t_disabled();
    t_m_and_modulator();
    t_analog_nm();
    t_bitclocks();
    t_auto();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
